// file: logic/tss_pkg.sv
// Purpose: Constants for the temperature sense, sleep and wake control block.
// Assumes: APB byte address = 4 x printed location index (some locations are odd).
// Notes:   Times are in seconds or milliseconds; cycle counts derive from the 100 MHz clock.
package tss_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SECOND_S        = 1;
    localparam int unsigned CYC_PER_SEC     = CLK_HZ * SECOND_S;
    localparam int unsigned COMMIT_MS       = 6;
    localparam int unsigned COMMIT_CYC      = CLK_HZ / 1000 * COMMIT_MS;
    localparam int unsigned CONV_MS         = 1;
    localparam int unsigned CONV_CYC        = CLK_HZ / 1000 * CONV_MS;
    // Register indices as printed; byte address is four times the index.
    localparam logic [15:0] IDX_TEMP_REF    = 16'h230a;
    localparam logic [15:0] IDX_COEF_A      = 16'h2508;
    localparam logic [15:0] IDX_COEF_B      = 16'h250a;
    localparam logic [15:0] IDX_LIM_BASE    = 16'h2519;
    localparam logic [15:0] IDX_LIM_MAX     = 16'h251b;
    localparam logic [15:0] IDX_LIM_MIN     = 16'h251c;
    localparam logic [15:0] IDX_LIM_FILT    = 16'h251d;
    localparam logic [15:0] IDX_WAKE_DUR    = 16'h2880;
    localparam logic [15:0] IDX_RESULT      = 16'h2881;
    localparam logic [15:0] IDX_COEF_C      = 16'h289c;
    localparam logic [15:0] IDX_TCTRL       = 16'h28a0;
    localparam logic [15:0] IDX_RST_CAUSE   = 16'h28b0;
    localparam logic [15:0] IDX_WAKE_FLAGS  = 16'h28b1;
    localparam logic [15:0] IDX_SLEEP_CTRL  = 16'h28b2;
    localparam logic [15:0] IDX_CMD         = 16'h28b4;
    localparam logic [15:0] IDX_PIN_CFG     = 16'h28c0;
    // Field positions.
    localparam int unsigned TC_PER_LSB      = 0;
    localparam int unsigned TC_BUSY_BIT     = 3;
    localparam int unsigned TC_BAT_BIT      = 4;
    localparam int unsigned TC_PWR_BIT      = 6;
    localparam int unsigned TC_BSEL_BIT     = 7;
    localparam int unsigned WF_P55_BIT      = 0;
    localparam int unsigned WF_P4_BIT       = 2;
    localparam int unsigned BUTTON_WAKE_FLAG_BIT       = 3;
    localparam int unsigned RX_WAKE_FLAG_BIT       = 4;
    localparam int unsigned TEMP_WAKE_FLAG_BIT     = 6;
    localparam int unsigned SC_ARM_BIT      = 5;
    localparam int unsigned SC_SLEEP_BIT    = 7;
    localparam int unsigned CMD_START_BIT   = 6;
    localparam int unsigned CMD_WD_BIT      = 7;
    localparam int unsigned RC_LSB          = 2;
    localparam logic [5:0]  RC_COLD_RESET   = 6'h20;
    localparam logic [2:0]  PER_OFF         = 3'h0;
    localparam logic [2:0]  PER_CONT        = 3'h7;
    localparam int unsigned PER_BASE_EXP    = 3;
    localparam int unsigned WD_TIMEOUT_SEC  = 2;
    typedef enum logic [2:0] {
        TSS_MISSION = 3'b001,
        TSS_SLEEP   = 3'b010,
        TSS_DISPLAY = 3'b100
    } tss_mode_t;
endpackage

// file: logic/tss_temp_sleep_ctrl.sv
// Purpose: Temperature conversion scheduler, limit check, wake timer and wake/reset causes.
// Assumes: APB slave, zero wait state; pins pass two flip-flops before use.
// Notes:   Analog conversion is modelled by a fixed busy time and a sampled ADC input word.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module tss_temp_sleep_ctrl
    import tss_pkg::*;
#(
    parameter int unsigned SEC_CYC    = CYC_PER_SEC,
    parameter int unsigned COMMIT_LEN = COMMIT_CYC,
    parameter int unsigned CONV_LEN   = CONV_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] adcResult,
    input  wire logic        systemPowerOk,
    input  wire logic        displayOnlyReq,
    input  wire logic        pushButtonInput,
    input  wire logic        rxInput,
    input  wire logic        pin4Input,
    input  wire logic        pin55Input,
    input  wire logic [5:0]  resetCauseIn,
    output logic             sleepMode,
    output logic             convActive,
    output logic             batteryMeasure,
    output logic             batterySelect,
    output logic             sensorSupplySel,
    output logic             watchdogOverflow
);
    // Two-stage synchronisers for every asynchronous pin.
    logic [5:0] syncA;
    logic [5:0] syncB;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 6'h00;
            syncB <= 6'h00;
        end else begin
            syncA <= {systemPowerOk, displayOnlyReq, pushButtonInput, rxInput, pin4Input,
                      pin55Input};
            syncB <= syncA;
        end
    end
    logic pwrOk, dispReq, btnIn, rxIn, p4In, p55In;
    assign {pwrOk, dispReq, btnIn, rxIn, p4In, p55In} = syncB;

    // Register state.
    logic [12:0] tempRef;
    logic [9:0]  coefA;
    logic [11:0] coefB;
    logic [11:0] coefC;
    logic [10:0] limBase;
    logic [6:0]  limMax;
    logic [6:0]  limMin;
    logic [3:0]  limFilt;
    logic [7:0]  wakeDur;
    logic [15:0] tempResult;
    logic [2:0]  period;
    logic        ctrlBusy;
    logic        oneShot;
    logic        wakeArm;
    logic [1:0]  pinWakeCfg;
    logic [5:0]  resetCause;
    logic        pin4Flag, pin55Flag, btnFlag, rxFlag, tempFlag;
    tss_mode_t   mode;

    // APB decode: index is byte address divided by four.
    logic [15:0] idx;
    logic        wrEn;
    logic        rdEn;
    assign idx  = paddr[17:2];
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    logic        mapped;
    logic [31:0] rdVal;
    always_comb begin
        mapped = 1'b1;
        rdVal  = 32'h0000_0000;
        unique case (idx)
            IDX_TEMP_REF:   rdVal[12:0] = tempRef;
            IDX_COEF_A:     rdVal[9:0]  = coefA;
            IDX_COEF_B:     rdVal[11:0] = coefB;
            IDX_COEF_C:     rdVal[11:0] = coefC;
            IDX_LIM_BASE:   rdVal[10:0] = limBase;
            IDX_LIM_MAX:    rdVal[6:0]  = limMax;
            IDX_LIM_MIN:    rdVal[6:0]  = limMin;
            IDX_LIM_FILT:   rdVal[3:0]  = limFilt;
            IDX_WAKE_DUR:   rdVal[7:0]  = wakeDur;
            IDX_RESULT:     rdVal[15:0] = tempResult;
            IDX_TCTRL: begin
                rdVal[TC_PER_LSB +: 3] = period;
                rdVal[TC_BUSY_BIT]     = ctrlBusy;
                rdVal[TC_BAT_BIT]      = batteryMeasure;
                rdVal[TC_PWR_BIT]      = sensorSupplySel;
                rdVal[TC_BSEL_BIT]     = batterySelect;
            end
            IDX_RST_CAUSE:  rdVal[RC_LSB +: 6] = resetCause;
            IDX_WAKE_FLAGS: begin
                rdVal[WF_P55_BIT]  = pin55Flag;
                rdVal[WF_P4_BIT]   = pin4Flag;
                rdVal[BUTTON_WAKE_FLAG_BIT]   = btnFlag;
                rdVal[RX_WAKE_FLAG_BIT]   = rxFlag;
                rdVal[TEMP_WAKE_FLAG_BIT] = tempFlag;
            end
            IDX_SLEEP_CTRL: rdVal[SC_ARM_BIT] = wakeArm;
            IDX_CMD:        rdVal[CMD_START_BIT] = (period == PER_OFF) ? oneShot : convActive;
            IDX_PIN_CFG:    rdVal[1:0] = pinWakeCfg;
            default:        mapped = 1'b0;
        endcase
    end

    // Zero-wait APB: read data registered in setup, answered in access phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rdEn) begin
                prdata <= rdVal;
            end
        end
    end

    logic wrOk;
    assign wrOk = wrEn && pready && mapped;

    // Plain software registers; compensation coefficients and limits reset to zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coefA      <= 10'h000;
            coefB      <= 12'h000;
            coefC      <= 12'h000;
            limBase    <= 11'h000;
            limMax     <= 7'h00;
            limMin     <= 7'h00;
            limFilt    <= 4'h0;
            wakeDur    <= 8'h00;
            pinWakeCfg <= 2'b00;
        end else if (wrOk) begin
            unique case (idx)
                IDX_COEF_A:   coefA      <= pwdata[9:0];
                IDX_COEF_B:   coefB      <= pwdata[11:0];
                IDX_COEF_C:   coefC      <= pwdata[11:0];
                IDX_LIM_BASE: limBase    <= pwdata[10:0];
                IDX_LIM_MAX:  limMax     <= pwdata[6:0];
                IDX_LIM_MIN:  limMin     <= pwdata[6:0];
                IDX_LIM_FILT: limFilt    <= pwdata[3:0];
                IDX_WAKE_DUR: wakeDur    <= pwdata[7:0];
                IDX_PIN_CFG:  pinWakeCfg <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Control byte with commit interlock: the commit time blocks further writes.
    logic [22:0] commitCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period          <= 3'h0;
            batteryMeasure  <= 1'b0;
            batterySelect   <= 1'b0;
            sensorSupplySel <= 1'b0;
            ctrlBusy        <= 1'b0;
            commitCnt       <= 23'h00_0000;
        end else if (wrOk && idx == IDX_TCTRL && !ctrlBusy) begin
            period          <= pwdata[TC_PER_LSB +: 3];
            batteryMeasure  <= pwdata[TC_BAT_BIT];
            batterySelect   <= pwdata[TC_BSEL_BIT];
            sensorSupplySel <= pwdata[TC_PWR_BIT] && mode != TSS_SLEEP;
            ctrlBusy        <= 1'b1;
            commitCnt       <= 23'(COMMIT_LEN - 1);
        end else begin
            if (mode == TSS_SLEEP) begin
                sensorSupplySel <= 1'b0;
            end
            if (ctrlBusy) begin
                if (commitCnt == 23'h00_0000) begin
                    ctrlBusy <= 1'b0;
                end else begin
                    commitCnt <= commitCnt - 23'h00_0001;
                end
            end
        end
    end

    // One-second tick for the period scheduler; the wake timer keeps its own second count.
    logic [26:0] secCnt;
    logic        secTick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secCnt  <= 27'h000_0000;
            secTick <= 1'b0;
        end else begin
            secTick <= secCnt == 27'(SEC_CYC - 1);
            secCnt  <= (secCnt == 27'(SEC_CYC - 1)) ? 27'h000_0000 : secCnt + 27'h000_0001;
        end
    end

    // Scheduler runs regardless of power mode.
    logic [9:0] perSec;
    logic [9:0] perLen;
    logic       autoDue;
    assign perLen = 10'(1 << (PER_BASE_EXP + period));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perSec  <= 10'h000;
            autoDue <= 1'b0;
        end else begin
            autoDue <= 1'b0;
            if (period == PER_OFF || period == PER_CONT) begin
                perSec <= 10'h000;
            end else if (secTick) begin
                if (perSec >= perLen - 10'h001) begin
                    perSec  <= 10'h000;
                    autoDue <= 1'b1;
                end else begin
                    perSec <= perSec + 10'h001;
                end
            end
        end
    end

    // Conversion engine and one-shot trigger.
    logic [19:0] convCnt;
    logic        convDone;
    logic        startReq;
    assign startReq = wrOk && idx == IDX_CMD && pwdata[CMD_START_BIT] && period == PER_OFF
                      && mode != TSS_SLEEP;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convActive <= 1'b0;
            convCnt    <= 20'h0_0000;
            convDone   <= 1'b0;
            oneShot    <= 1'b0;
            tempResult <= 16'h0000;
            tempRef    <= 13'h0000;
        end else begin
            convDone <= 1'b0;
            if (startReq) begin
                oneShot <= 1'b1;
            end
            if (!convActive && (startReq || autoDue || period == PER_CONT)) begin
                convActive <= 1'b1;
                convCnt    <= 20'(CONV_LEN - 1);
            end else if (convActive) begin
                if (convCnt == 20'h0_0000) begin
                    convActive <= 1'b0;
                    convDone   <= 1'b1;
                    tempResult <= adcResult;
                    oneShot    <= startReq;
                end else begin
                    convCnt <= convCnt - 20'h0_0001;
                end
            end
        end
    end

    // Range check on the filtered result; filter is a shift-weighted running average.
    logic [15:0] filtAcc;
    logic [15:0] lowLim;
    logic [15:0] highLim;
    logic        outOfRange;
    assign lowLim  = {5'h00, limBase} - {9'h000, limMin};
    assign highLim = {5'h00, limBase} + {9'h000, limMax};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filtAcc    <= 16'h0000;
            outOfRange <= 1'b0;
        end else begin
            outOfRange <= 1'b0;
            if (convDone) begin
                filtAcc <= filtAcc + ((tempResult - filtAcc) >>> limFilt);
                outOfRange <= (filtAcc < lowLim) || (filtAcc > highLim);
            end
        end
    end

    // Power mode: sleep on command unless powered; wake on timer, button, power, temperature out of range or rx edge.
    logic [7:0] wakeSec;
    logic       wakeRun;
    logic       wakeExpire;
    logic       btnPrev, rxPrev, p4Prev, p55Prev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= TSS_MISSION;
        end else begin
            unique case (mode)
                TSS_MISSION: begin
                    if (wrOk && idx == IDX_SLEEP_CTRL && pwdata[SC_SLEEP_BIT] && !pwrOk) begin
                        mode <= TSS_SLEEP;
                    end else if (dispReq) begin
                        mode <= TSS_DISPLAY;
                    end
                end
                TSS_SLEEP, TSS_DISPLAY: begin
                    if (wakeExpire || (btnIn && !btnPrev) || pwrOk || outOfRange
                        || (rxIn && !rxPrev)) begin
                        mode <= TSS_MISSION;
                    end
                end
                default: mode <= TSS_MISSION;
            endcase
        end
    end

    // Wake timer's own second count, held at zero in mission mode.
    logic [26:0] wakeCyc;
    logic        wakeTick;
    assign wakeTick = wakeCyc == 27'(SEC_CYC - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeCyc <= 27'h000_0000;
        end else begin
            wakeCyc <= (wakeTick || mode == TSS_MISSION) ? 27'h000_0000 : wakeCyc + 27'h000_0001;
        end
    end

    // Wake timer: loaded when armed, counts only outside mission mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeArm    <= 1'b0;
            wakeSec    <= 8'h00;
            wakeRun    <= 1'b0;
            wakeExpire <= 1'b0;
        end else begin
            wakeExpire <= 1'b0;
            if (wrOk && idx == IDX_SLEEP_CTRL) begin
                wakeArm <= pwdata[SC_ARM_BIT];
                if (pwdata[SC_ARM_BIT]) begin
                    wakeSec <= wakeDur;
                    wakeRun <= 1'b1;
                end
            end else if (wakeRun && mode != TSS_MISSION && wakeTick) begin
                if (wakeSec == 8'h00) begin
                    wakeRun    <= 1'b0;
                    wakeArm    <= 1'b0;
                    wakeExpire <= 1'b1;
                end else begin
                    wakeSec <= wakeSec - 8'h01;
                end
            end
        end
    end

    // Wake cause flags; a new pin 4/55 edge wins over clearing on the next sleep command.
    logic sleepEnter;
    assign sleepEnter = mode == TSS_MISSION && wrOk && idx == IDX_SLEEP_CTRL
                        && pwdata[SC_SLEEP_BIT] && !pwrOk;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            btnPrev   <= 1'b0;
            rxPrev    <= 1'b0;
            p4Prev    <= 1'b0;
            p55Prev   <= 1'b0;
            pin4Flag  <= 1'b0;
            pin55Flag <= 1'b0;
            btnFlag   <= 1'b0;
            rxFlag    <= 1'b0;
            tempFlag  <= 1'b0;
        end else begin
            btnPrev <= btnIn;
            rxPrev  <= rxIn;
            p4Prev  <= p4In;
            p55Prev <= p55In;
            pin4Flag  <= pinWakeCfg[0] && ((p4In && !p4Prev) || (pin4Flag && !sleepEnter));
            pin55Flag <= pinWakeCfg[1] && ((p55In && !p55Prev) || (pin55Flag && !sleepEnter));
            if (mode != TSS_MISSION) begin
                btnFlag  <= btnFlag || (btnIn && !btnPrev);
                rxFlag   <= rxFlag || (rxIn && !rxPrev);
                tempFlag <= tempFlag || outOfRange;
            end else if (sleepEnter) begin
                btnFlag  <= 1'b0;
                rxFlag   <= 1'b0;
                tempFlag <= 1'b0;
            end
        end
    end

    // Reset cause captured once after release.
    logic capDone;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetCause <= RC_COLD_RESET;
            capDone    <= 1'b0;
        end else if (!capDone) begin
            resetCause <= resetCauseIn;
            capDone    <= 1'b1;
        end
    end

    // Watchdog: restarted by writing 1 to the restart bit.
    logic [31:0] wdCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt            <= 32'h0000_0000;
            watchdogOverflow <= 1'b0;
        end else if (wrOk && idx == IDX_CMD && pwdata[CMD_WD_BIT]) begin
            wdCnt            <= 32'h0000_0000;
            watchdogOverflow <= 1'b0;
        end else if (wdCnt == 32'(SEC_CYC * WD_TIMEOUT_SEC)) begin
            watchdogOverflow <= 1'b1;
        end else begin
            wdCnt <= wdCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepMode <= 1'b0;
        end else begin
            sleepMode <= mode == TSS_SLEEP;
        end
    end
endmodule

// file: tb/tss_props.sv
// Purpose: Port-level properties of the temperature sense and sleep controller.
// Assumes: Conversions last at least eight cycles; APB answers with no wait state.
// Notes:   Bound to the controller below; pin checks allow for the synchroniser.
`timescale 1ns/1ns
module tss_props
    import tss_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        systemPowerOk,
    input wire logic        sleepMode,
    input wire logic        convActive,
    input wire logic        sensorSupplySel,
    input wire logic        watchdogOverflow
);
    logic done;
    logic wrCmd;
    logic wrSleep;
    // A transfer completes where the access phase sees ready.
    assign done    = psel && penable && pready;
    assign wrCmd   = done && pwrite && paddr == {14'h0000, IDX_CMD, 2'b00} && pwdata[7];
    assign wrSleep = done && pwrite && paddr == {14'h0000, IDX_SLEEP_CTRL, 2'b00} && pwdata[7];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Six settled power cycles let the synchroniser agree.
    sequence s_pwrOn; systemPowerOk [*6] ##0 wrSleep; endsequence
    sequence s_pwrOff; (!systemPowerOk) [*6] ##0 wrSleep; endsequence
    property p_answer; psel && !penable |=> pready; endproperty
    property p_ready; pready |-> psel && penable && $past(psel && !penable); endproperty
    property p_conv; $rose(convActive) |-> convActive [*8]; endproperty
    property p_noSleep; s_pwrOn |=> !sleepMode; endproperty
    property p_sleep; s_pwrOff |-> ##[1:3] sleepMode; endproperty
    property p_supply; sleepMode && $past(sleepMode) |-> !sensorSupplySel; endproperty
    property p_wdog; wrCmd |=> !watchdogOverflow; endproperty
    property p_result;
        done && !pwrite && paddr == {14'h0000, IDX_RESULT, 2'b00} |-> !pslverr;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    a_ready: assert property (p_ready) else $error("ready outside access phase");
    a_conv: assert property (p_conv) else $error("conversion too short");
    a_noSleep: assert property (p_noSleep) else $error("slept on power");
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    a_supply: assert property (p_supply) else $error("supply not forced");
    a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
    a_result: assert property (p_result) else $error("result refused");
endmodule

bind tss_temp_sleep_ctrl tss_props u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .systemPowerOk(systemPowerOk), .sleepMode(sleepMode), .convActive(convActive),
    .sensorSupplySel(sensorSupplySel), .watchdogOverflow(watchdogOverflow)
);

// file: tb/tb_temp_sense_sleep_wake_ctrl.sv
// Purpose: Self-checking bench for the temperature sense and sleep controller.
// Assumes: A second is SEC cycles; commit 20 and conversion 10 cycles.
// Notes:   A model holds the expected value of each coefficient, limit and wake duration register.
`timescale 1ns/1ns
module tb_temp_sense_sleep_wake_ctrl
    import tss_pkg::*;
;
    localparam int SEC = 100;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        systemPowerOk = 1'b1, pushButtonInput = 1'b0, pin4Input = 1'b0;
    logic        pin55Input = 1'b0, pready, pslverr, sleepMode, convActive, err;
    logic        batteryMeasure, batterySelect, sensorSupplySel, watchdogOverflow;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, q;
    logic [15:0] adcResult = 16'h0000;
    logic [5:0]  resetCauseIn = 6'h00;
    logic [15:0] idxs [8] = '{IDX_COEF_A, IDX_COEF_B, IDX_LIM_BASE, IDX_LIM_MAX,
                              IDX_LIM_MIN, IDX_LIM_FILT, IDX_WAKE_DUR, IDX_COEF_C};
    int          wid [8] = '{10, 12, 11, 7, 7, 4, 8, 12};
    int          mdl [8];
    int          bad_count = 0, samples_checked = 0, n, m;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    tss_temp_sleep_ctrl #(.SEC_CYC(SEC), .COMMIT_LEN(20), .CONV_LEN(10)) uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adcResult(adcResult), .systemPowerOk(systemPowerOk),
        .displayOnlyReq(1'b0), .pushButtonInput(pushButtonInput), .rxInput(1'b0),
        .pin4Input(pin4Input), .pin55Input(pin55Input), .resetCauseIn(resetCauseIn),
        .sleepMode(sleepMode), .convActive(convActive), .batteryMeasure(batteryMeasure),
        .batterySelect(batterySelect), .sensorSupplySel(sensorSupplySel),
        .watchdogOverflow(watchdogOverflow));

    // One APB transfer, held until ready is seen at an edge.
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 14'h0000, idx, 2'b00, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        q = prdata;
        err = pslverr;
        bad_count += (k >= 100);
        {psel, penable} <= 2'b00;
    endtask

    // Counts edges until s is v, at most lim.
    task automatic waitv(ref logic s, input logic v, input int lim);
        for (n = 0; s !== v && n < lim; n++) @(posedge clk);
    endtask

    // Counts every comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Hang guard: the sequence needs roughly 17k cycles.
    initial begin
        #600_000;
        bad_count++;
        end_of_test();
    end

    // Main sequence; random cause bits expose a stuck capture.
    initial begin
        void'($urandom(32'h5e15));
        resetCauseIn <= 6'($urandom());
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, IDX_RST_CAUSE, 0);
        chk("cause", {24'h00_0000, resetCauseIn, 2'b00}, q);
        foreach (idxs[i]) begin
            m = $urandom();
            mdl[i] = m & ((1 << wid[i]) - 1);
            bus(0, idxs[i], 0);
            chk("reset value", 0, q);
            bus(1, idxs[i], m);
            bus(0, idxs[i], 0);
            chk("read back", mdl[i], q);
        end
        bus(0, 16'h1234, 0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, q);
        // A control write while committing is dropped.
        m = $urandom() & 32'h0000_00d0;
        bus(1, IDX_TCTRL, m);
        bus(1, IDX_TCTRL, m ^ 32'h0000_00d0);
        bus(0, IDX_TCTRL, 0);
        chk("busy", 1, q[TC_BUSY_BIT]);
        repeat (30) @(posedge clk);
        bus(0, IDX_TCTRL, 0);
        chk("control", m, q);
        chk("outputs", {m[7], m[6], m[4]}, {batterySelect, sensorSupplySel, batteryMeasure});
        adcResult <= 16'($urandom());
        bus(1, IDX_CMD, 32'h0000_0040);
        bus(0, IDX_CMD, 0);
        chk("one shot", 1, q[CMD_START_BIT]);
        waitv(convActive, 0, 50);
        bus(0, IDX_RESULT, 0);
        chk("result", {16'h0000, adcResult}, q);
        bus(0, IDX_CMD, 0);
        chk("one shot done", 0, q[CMD_START_BIT]);
        // Rise-to-rise spacing of automatic conversions.
        for (int p = 1; p <= 2; p++) begin
            bus(1, IDX_TCTRL, p);
            waitv(convActive, 1, 20000);
            bus(0, IDX_CMD, 0);
            chk("auto busy", 1, q[CMD_START_BIT]);
            waitv(convActive, 0, 50);
            bus(0, IDX_CMD, 0);
            chk("auto idle", 0, q[CMD_START_BIT]);
            waitv(convActive, 1, 20000);
            waitv(convActive, 0, 50);
            m = n;
            waitv(convActive, 1, 20000);
            chk("interval", (1 << (3 + p)) * SEC, m + n);
        end
        bus(1, IDX_TCTRL, 7);
        waitv(convActive, 1, 200);
        waitv(convActive, 0, 50);
        waitv(convActive, 1, 50);
        chk("continuous", 1, n < 3);
        repeat (30) @(posedge clk);
        bus(1, IDX_TCTRL, 32'h0000_0040);
        waitv(convActive, 0, 50);
        waitv(convActive, 1, 2000);
        chk("off", 2000, n);
        // Wake timer armed with sleep, power absent.
        systemPowerOk <= 1'b0;
        m = $urandom_range(2);
        bus(1, IDX_WAKE_DUR, m);
        bus(1, IDX_SLEEP_CTRL, 32'h0000_00a0);
        waitv(sleepMode, 1, 5);
        waitv(sleepMode, 0, 1000);
        chk("wake time", 1, n >= (m + 1) * SEC - 2 && n <= (m + 1) * SEC + 3);
        bus(1, IDX_SLEEP_CTRL, 32'h0000_0080);
        bus(1, IDX_CMD, 32'h0000_0040);
        waitv(convActive, 1, 30);
        chk("asleep one shot", 30, n);
        pushButtonInput <= 1'b1;
        waitv(sleepMode, 0, 5000);
        pushButtonInput <= 1'b0;
        bus(0, IDX_WAKE_FLAGS, 0);
        chk("button flag", 1, q[BUTTON_WAKE_FLAG_BIT]);
        bus(1, IDX_SLEEP_CTRL, 32'h0000_0080);
        systemPowerOk <= 1'b1;
        waitv(sleepMode, 1, 5);
        waitv(sleepMode, 0, 50);
        chk("power wake", 1, n < 50);
        repeat (6) @(posedge clk);
        bus(1, IDX_SLEEP_CTRL, 32'h0000_0080);
        repeat (3) @(posedge clk);
        chk("no sleep", 0, sleepMode);
        bus(1, IDX_PIN_CFG, 32'h0000_0003);
        {pin4Input, pin55Input} <= 2'b11;
        repeat (10) @(posedge clk);
        bus(0, IDX_WAKE_FLAGS, 0);
        chk("pin flags", 5, q & 5);
        bus(1, IDX_PIN_CFG, 0);
        bus(0, IDX_WAKE_FLAGS, 0);
        chk("pin flags off", 0, q & 5);
        chk("overflow", 1, watchdogOverflow);
        bus(1, IDX_CMD, 32'h0000_0080);
        repeat (2) @(posedge clk);
        chk("restart", 0, watchdogOverflow);
        end_of_test();
    end
endmodule
